// ==== rtl/isf_map.svh ====
// register map, field positions and reset values of the status-flag block
//
// Functional notes
// RQ1 - master transmit: bit 15 shows slave answer, one for NACK, zero for ACK
// RQ2 - ack result is updated at the end of every slave ack slot
// RQ3 - bit 14 is high while a master byte plus ack is in progress
// RQ4 - bit 14 rises when master transmit starts, falls after slave ack
// RQ5 - slave only: bit 13 set on 8th SCL fall, cleared on 9th rise
// RQ6 - status bits 12 and 11 always read as zero
// RQ7 - bit 10 set when a bus collision is seen during master operation
// RQ8 - bit 9 set when received address equals general call address
// RQ9 - bit 8 set when second byte of own 10-bit address matches
// RQ10 - general call and 10-bit match flags clear on Stop
// RQ11 - transmit write while busy is dropped and sets bit 7
// RQ12 - write collision stays set until software clears it
// RQ13 - bit 6 set when a byte arrives while receive holding still full
// RQ14 - receive overrun stays set until software clears it
// RQ15 - slave mode: bit 5 cleared on own address match
// RQ16 - slave mode: bit 5 set on reception of a data byte
// RQ17 - software may clear bits 10, 7, 6 only; others read-only; reset zero
// RQ18 - start, stop, direction, rx full, tx full readable in low byte
`ifndef ISF_MAP_SVH
`define ISF_MAP_SVH
`define ISF_OFF_STATUS 8'h00
`define ISF_OFF_CTRL   8'h04
`define ISF_OFF_OWN    8'h08
`define ISF_OFF_TXDATA 8'h0C
`define ISF_OFF_RXDATA 8'h10
`define ISF_B_BCL      10
`define ISF_B_WCOL     7
`define ISF_B_OV       6
`define ISF_RST_STATUS 16'h0000
`define ISF_RST_CTRL   3'h0
`define ISF_RST_OWN    10'h000
`define ISF_RST_BYTE   8'h00
`define ISF_BYTE_BITS  4'h8
`define ISF_ACK_BIT    4'h9
`define ISF_GC_ADDR    8'h00
`define ISF_TEN_HDR    5'h1E
`endif

// ==== rtl/isf_pkg.sv ====
// types shared by the status-flag block
package isf_pkg;
    typedef struct packed {
        logic       ack;
        logic       txa;
        logic       akw;
        logic [1:0] unimpl;
        logic       bus_collision_flag;
        logic       gc;
        logic       a10;
        logic       wcol;
        logic       ov;
        logic       da;
        logic       p;
        logic       s;
        logic       rw;
        logic       rx_full;
        logic       tx_full;
    } isf_status_t;

    typedef struct packed {
        logic gc_en;
        logic ten_bit;
        logic master;
    } isf_ctrl_t;

    typedef enum logic [3:0] {
        ST_IDLE  = 4'b0001,
        ST_ADDR  = 4'b0010,
        ST_ADDR2 = 4'b0100,
        ST_DATA  = 4'b1000
    } isf_state_t;
endpackage

// ==== rtl/isf_status.sv ====
// two-wire bus status flags with apb register access
`timescale 1ns/1ps
`include "isf_map.svh"
`default_nettype none
module isf_status (
    input  wire logic        MCLK_IN,
    input  wire logic        RST_N_IN,
    input  wire logic        SCL_IN,
    input  wire logic        SDA_IN,
    output logic             SDA_OUT,
    output logic             SDA_OE_OUT,
    input  wire logic        PSEL_IN,
    input  wire logic        PENABLE_IN,
    input  wire logic        PWRITE_IN,
    input  wire logic [7:0]  PADDR_IN,
    input  wire logic [31:0] PWDATA_IN,
    output logic [31:0]      PRDATA_OUT,
    output logic             PREADY_OUT,
    output logic             PSLVERR_OUT
);
    // link domain: shift in sda on each scl rise
    logic [7:0] rx_shift_reg;

    always_ff @(posedge SCL_IN) begin
        rx_shift_reg <= {rx_shift_reg[6:0], SDA_IN};
    end

    // pin synchronisers; stage one feeds stage two only
    logic [1:0] scl_s1_q, scl_s1_d;
    logic [1:0] sda_s1_q, sda_s1_d;
    logic       scl_p_q, sda_p_q;

    always_comb begin
        scl_s1_d = {scl_s1_q[0], SCL_IN};
        sda_s1_d = {sda_s1_q[0], SDA_IN};
    end

    always_ff @(posedge MCLK_IN) begin
        scl_s1_q <= scl_s1_d;
        sda_s1_q <= sda_s1_d;
        scl_p_q  <= scl_s1_q[1];
        sda_p_q  <= sda_s1_q[1];
    end

    logic scl_h, sda_h, rise, fall, start_ev, stop_ev;
    assign scl_h    = scl_s1_q[1];
    assign sda_h    = sda_s1_q[1];
    assign rise     = scl_h & ~scl_p_q;
    assign fall     = ~scl_h & scl_p_q;
    assign start_ev = scl_h & scl_p_q & ~sda_h & sda_p_q;
    assign stop_ev  = scl_h & scl_p_q & sda_h & ~sda_p_q;

    // apb decode: zero wait states
    logic acc, wr, rd_setup;
    logic hit_st, hit_ct, hit_ow, hit_tx, hit_rx, mapped;
    assign acc      = PSEL_IN & PENABLE_IN;
    assign wr       = acc & PWRITE_IN;
    assign rd_setup = PSEL_IN & ~PENABLE_IN & ~PWRITE_IN;
    assign hit_st   = PADDR_IN == `ISF_OFF_STATUS;
    assign hit_ct   = PADDR_IN == `ISF_OFF_CTRL;
    assign hit_ow   = PADDR_IN == `ISF_OFF_OWN;
    assign hit_tx   = PADDR_IN == `ISF_OFF_TXDATA;
    assign hit_rx   = PADDR_IN == `ISF_OFF_RXDATA;
    assign mapped   = hit_st | hit_ct | hit_ow | hit_tx | hit_rx;
    assign PREADY_OUT  = 1'b1;
    assign PSLVERR_OUT = acc & ~mapped;

    // block state
    isf_pkg::isf_status_t sts_q, sts_d;
    isf_pkg::isf_ctrl_t   ctl_q, ctl_d;
    isf_pkg::isf_state_t  st_q, st_d;
    logic [9:0]  own_q, own_d;
    logic [7:0]  txh_q, txh_d, rxh_q, rxh_d, out_q, out_d;
    logic [3:0]  cnt_q, cnt_d;
    logic        ack_smp_q, ack_smp_d;
    logic        drv_q, drv_d;
    logic [31:0] prd_q, prd_d;

    logic [7:0] byte_in;
    logic       busy, tx_wr, sts_wr, ld, slave_on, ack_fall, byte_fall;
    logic       coll;
    // shift reg is stable from the 8th rise to the 9th rise, microseconds
    // after the synchronised fall that qualifies this capture
    assign byte_in   = rx_shift_reg;
    assign busy      = sts_q.tx_full | sts_q.txa;
    assign tx_wr     = wr & hit_tx;
    assign sts_wr    = wr & hit_st;
    assign slave_on  = ~ctl_q.master;
    assign byte_fall = fall & (cnt_q == `ISF_BYTE_BITS);
    assign ack_fall  = fall & (cnt_q == `ISF_ACK_BIT);
    // master start: only once a frame is open and scl is low
    assign ld   = ctl_q.master & sts_q.tx_full & ~sts_q.txa & sts_q.s & ~scl_h;
    // a released one read back as zero means another master won
    assign coll = sts_q.txa & rise & ~drv_q & out_q[7] & ~sda_h
                  & (cnt_q < `ISF_BYTE_BITS);

    always_comb begin
        sts_d     = sts_q;
        ctl_d     = ctl_q;
        st_d      = st_q;
        own_d     = own_q;
        txh_d     = txh_q;
        rxh_d     = rxh_q;
        out_d     = out_q;
        cnt_d     = cnt_q;
        ack_smp_d = ack_smp_q;
        drv_d     = drv_q;
        prd_d     = prd_q;

        // software writes; clearable bits clear on a written zero
        if (sts_wr) begin
            if (!PWDATA_IN[`ISF_B_BCL])
                sts_d.bus_collision_flag = 1'b0; // RQ17
            if (!PWDATA_IN[`ISF_B_WCOL])
                sts_d.wcol = 1'b0; // RQ12
            if (!PWDATA_IN[`ISF_B_OV])
                sts_d.ov = 1'b0; // RQ14
        end
        if (wr && hit_ct)
            ctl_d = isf_pkg::isf_ctrl_t'(PWDATA_IN[2:0]);
        if (wr && hit_ow)
            own_d = PWDATA_IN[9:0];
        if (tx_wr) begin
            if (busy) begin
                sts_d.wcol = 1'b1; // RQ11
            end else begin
                txh_d     = PWDATA_IN[7:0];
                sts_d.tx_full = 1'b1; // RQ18
            end
        end
        if (acc && !PWRITE_IN && hit_rx)
            sts_d.rx_full = 1'b0;

        // bit position within the byte, restarted by start or restart and at the ack-slot fall
        if (rise)
            cnt_d = cnt_q + 4'h1;
        if (ack_fall)
            cnt_d = 4'h0;
        if (rise && cnt_q == `ISF_BYTE_BITS)
            ack_smp_d = sda_h;

        // master transmit
        if (ld) begin
            out_d     = txh_q;
            drv_d     = ~txh_q[7];
            sts_d.tx_full = 1'b0;
            sts_d.txa = 1'b1; // RQ3 RQ4
        end else if (sts_q.txa && fall) begin
            // falls one to seven move to the next bit; the eighth frees sda
            if (cnt_q < `ISF_BYTE_BITS) begin
                out_d = {out_q[6:0], 1'b0};
                drv_d = ~out_q[6];
            end else begin
                drv_d = 1'b0;
            end
            if (ack_fall) begin
                sts_d.ack = ack_smp_q; // RQ1 RQ2
                sts_d.txa = 1'b0; // RQ4
            end
        end
        if (coll) begin
            sts_d.bus_collision_flag = 1'b1; // RQ7
            sts_d.txa = 1'b0;
            drv_d     = 1'b0;
        end

        // slave address and data tracking
        if (slave_on && byte_fall && st_q != isf_pkg::ST_IDLE)
            sts_d.akw = 1'b1; // RQ5
        if (rise && cnt_q == `ISF_BYTE_BITS)
            sts_d.akw = 1'b0; // RQ5
        if (slave_on && byte_fall) begin
            case (st_q)
                isf_pkg::ST_IDLE: begin
                    st_d = isf_pkg::ST_IDLE;
                end
                isf_pkg::ST_ADDR: begin
                    sts_d.rw = byte_in[0];
                    if (ctl_q.gc_en && byte_in == `ISF_GC_ADDR) begin
                        sts_d.gc = 1'b1; // RQ8
                        sts_d.da = 1'b0; // RQ15
                        st_d     = isf_pkg::ST_DATA;
                    end else if (ctl_q.ten_bit) begin
                        if (byte_in[7:3] == `ISF_TEN_HDR
                            && byte_in[2:1] == own_q[9:8])
                            st_d = isf_pkg::ST_ADDR2;
                        else
                            st_d = isf_pkg::ST_IDLE;
                    end else if (byte_in[7:1] == own_q[6:0]) begin
                        sts_d.da = 1'b0; // RQ15
                        st_d     = isf_pkg::ST_DATA;
                    end else begin
                        st_d = isf_pkg::ST_IDLE;
                    end
                end
                isf_pkg::ST_ADDR2: begin
                    if (byte_in == own_q[7:0]) begin
                        sts_d.a10 = 1'b1; // RQ9
                        sts_d.da  = 1'b0; // RQ15
                        st_d      = isf_pkg::ST_DATA;
                    end else begin
                        st_d = isf_pkg::ST_IDLE;
                    end
                end
                isf_pkg::ST_DATA: begin
                    if (!sts_q.rw) begin
                        sts_d.da = 1'b1; // RQ16
                        if (sts_q.rx_full) begin
                            sts_d.ov = 1'b1; // RQ13
                        end else begin
                            rxh_d     = byte_in;
                            sts_d.rx_full = 1'b1;
                        end
                    end
                end
                default: begin
                    st_d = isf_pkg::ST_IDLE;
                end
            endcase
        end

        // bus conditions
        if (start_ev) begin
            sts_d.s   = 1'b1;
            sts_d.p   = 1'b0;
            cnt_d     = 4'h0;
            st_d      = isf_pkg::ST_ADDR;
            sts_d.akw = 1'b0;
        end
        if (stop_ev) begin
            sts_d.s   = 1'b0;
            sts_d.p   = 1'b1;
            sts_d.gc  = 1'b0; // RQ10
            sts_d.a10 = 1'b0; // RQ10
            sts_d.txa = 1'b0;
            sts_d.akw = 1'b0;
            drv_d     = 1'b0;
            st_d      = isf_pkg::ST_IDLE;
        end
        sts_d.unimpl = 2'h0; // RQ6

        // read data is fetched in the setup phase
        if (rd_setup) begin
            prd_d = 32'h0000_0000;
            if (hit_st)
                prd_d[15:0] = sts_d;
            if (hit_ct)
                prd_d[2:0] = ctl_q;
            if (hit_ow)
                prd_d[9:0] = own_q;
            if (hit_tx)
                prd_d[7:0] = txh_q;
            if (hit_rx)
                prd_d[7:0] = rxh_q;
        end
    end

    always_ff @(posedge MCLK_IN) begin
        if (!RST_N_IN) begin
            sts_q     <= `ISF_RST_STATUS; // RQ17
            ctl_q     <= `ISF_RST_CTRL;
            st_q      <= isf_pkg::ST_IDLE;
            own_q     <= `ISF_RST_OWN;
            txh_q     <= `ISF_RST_BYTE;
            rxh_q     <= `ISF_RST_BYTE;
            out_q     <= `ISF_RST_BYTE;
            cnt_q     <= 4'h0;
            ack_smp_q <= 1'b0;
            drv_q     <= 1'b0;
            prd_q     <= 32'h0000_0000;
        end else begin
            sts_q     <= sts_d;
            ctl_q     <= ctl_d;
            st_q      <= st_d;
            own_q     <= own_d;
            txh_q     <= txh_d;
            rxh_q     <= rxh_d;
            out_q     <= out_d;
            cnt_q     <= cnt_d;
            ack_smp_q <= ack_smp_d;
            drv_q     <= drv_d;
            prd_q     <= prd_d;
        end
    end

    // open drain: only ever pulls low
    assign SDA_OUT    = 1'b0;
    assign SDA_OE_OUT = drv_q;
    assign PRDATA_OUT = prd_q;

    default clocking cb @(posedge MCLK_IN); endclocking
    default disable iff (!RST_N_IN);

    logic clr_wcol, clr_ov;
    assign clr_wcol = sts_wr & ~PWDATA_IN[`ISF_B_WCOL];
    assign clr_ov   = sts_wr & ~PWDATA_IN[`ISF_B_OV];

    a_ack_update: assert property ( // RQ2
        sts_q.txa && ack_fall && !stop_ev && !coll
        |=> sts_q.ack == $past(ack_smp_q) && !sts_q.txa)
        else $error("ack result not updated at end of ack slot");
    a_tx_rise: assert property ( // RQ4
        ld && !stop_ev |=> sts_q.txa && !sts_q.tx_full)
        else $error("transmit active did not rise");
    a_tx_held: assert property ( // RQ3
        sts_q.txa && !fall && !stop_ev && !rise |=> sts_q.txa)
        else $error("transmit active dropped mid byte");
    a_ack_win: assert property ( // RQ5
        rise && cnt_q == `ISF_BYTE_BITS && !start_ev ##1 1
        |-> !sts_q.akw)
        else $error("ack window not cleared on 9th rise");
    a_unimpl_zero: assert property ( // RQ6
        rd_setup && hit_st |=> PRDATA_OUT[12:11] == 2'h0)
        else $error("unimplemented bits read nonzero");
    a_bcl_set: assert property ( // RQ7
        coll |=> sts_q.bus_collision_flag ##1 sts_q.bus_collision_flag || $past(sts_wr))
        else $error("collision flag not set");
    a_stop_clear: assert property ( // RQ10
        stop_ev |=> !sts_q.gc && !sts_q.a10 && sts_q.p)
        else $error("stop did not clear address flags");
    a_wcol_set: assert property ( // RQ11
        tx_wr && busy |=> sts_q.wcol && txh_q == $past(txh_q))
        else $error("write collision mishandled");
    a_wcol_hold: assert property ( // RQ12
        sts_q.wcol && !clr_wcol |=> sts_q.wcol)
        else $error("write collision cleared by itself");
    a_ov_hold: assert property ( // RQ14
        sts_q.ov && !clr_ov |=> sts_q.ov)
        else $error("overrun cleared by itself");
    a_ov_set: assert property ( // RQ13
        slave_on && byte_fall && st_q == isf_pkg::ST_DATA && !sts_q.rw
        && sts_q.rx_full && !stop_ev |=> sts_q.ov && rxh_q == $past(rxh_q))
        else $error("overrun not flagged");

    c_master_tx: cover property (ld ##[1:1000] ack_fall);
    c_slave_rx: cover property (sts_q.rx_full && !sts_q.da ##[1:1000] sts_q.da);
    c_ten_bit: cover property (st_q == isf_pkg::ST_ADDR2 ##[1:1000] sts_q.a10);
endmodule
`default_nettype wire

// ==== tb/isf_bus_peer.sv ====
// two-wire bus master model that drives the clock and data lines
`timescale 1ns/1ps
`default_nettype none
module isf_bus_peer (
    input  wire logic       lclk,
    input  wire logic       sda,
    output logic            scl,
    output logic            sda_oe,
    output logic            in_ack,
    output logic [7:0]      seen
);
    initial begin
        scl = 1'b1;
        sda_oe = 1'b0;
        in_ack = 1'b0;
        seen = 8'h00;
    end
    task automatic ph(input int n);
        repeat (n) @(posedge lclk);
    endtask
    // the clock stands high between frames; the pull-up holds data high
    task automatic start();
        sda_oe <= 1'b1;
        ph(40);
        scl <= 1'b0;
        ph(40);
    endtask
    task automatic stop();
        sda_oe <= 1'b1;
        ph(40);
        scl <= 1'b1;
        ph(40);
        sda_oe <= 1'b0;
        ph(40);
    endtask
    // a one bit releases the line so the block may drive it; data moves
    // a few ticks after the clock fall so no false start or stop is seen
    task automatic xbyte(input logic [7:0] b, input logic ack);
        for (int i = 7; i >= 0; i--) begin
            sda_oe <= ~b[i];
            ph(40);
            scl <= 1'b1;
            seen <= {seen[6:0], sda};
            ph(40);
            scl <= 1'b0;
            ph(4);
        end
        sda_oe <= ack;
        in_ack <= 1'b1;
        ph(200);
        scl <= 1'b1;
        in_ack <= 1'b0;
        ph(40);
        scl <= 1'b0;
        ph(4);
    endtask
endmodule
`default_nettype wire

// ==== tb/isf_status_tb_top.sv ====
// self-checking bench for the two-wire status-flag block
`timescale 1ns/1ps
`include "isf_map.svh"
`default_nettype none
module isf_status_tb_top;
    logic        clk;
    logic        rst_n;
    logic        lclk;
    logic        psel;
    logic        pen;
    logic        pwr;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        sda_o;
    logic        sda_oe;
    logic        scl;
    logic        peer_oe;
    logic        in_ack;
    logic [7:0]  seen;
    wire logic   sda;
    logic [31:0] rd;
    logic        er;
    logic [9:0]  own;
    logic [7:0]  d1;
    int          n_fail;
    int          tests_run;
    // open-drain line with pull-up: low while any party pulls
    assign sda = ~peer_oe & ~(sda_oe & ~sda_o);
    isf_status i_dut (.MCLK_IN(clk), .RST_N_IN(rst_n), .SCL_IN(scl),
        .SDA_IN(sda), .SDA_OUT(sda_o), .SDA_OE_OUT(sda_oe),
        .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
        .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(pslverr));
    isf_bus_peer i_peer (.lclk(lclk), .sda(sda), .scl(scl),
        .sda_oe(peer_oe), .in_ack(in_ack), .seen(seen));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        lclk = 1'b0;
        #3.7;
        forever #3 lclk = ~lclk;
    end
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic fail_out();
        n_fail++;
        close_out();
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        @(posedge clk);
        for (int k = 0; pready !== 1'b1; k++) begin
            if (k == 20) fail_out();
            @(posedge clk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd & m, e);
    endtask
    // reads the status while the peer holds the clock low in the ack slot
    task automatic bus_byte(input logic [7:0] b, input logic ack,
                            input logic [31:0] m, input logic [31:0] e);
        fork
            i_peer.xbyte(b, ack);
            begin
                for (int k = 0; in_ack !== 1'b1; k++) begin
                    if (k == 600) fail_out();
                    @(posedge clk);
                end
                repeat (10) @(posedge clk);
                rchk(`ISF_OFF_STATUS, m, e);
            end
        join
    endtask
    initial begin
        psel = 1'b0;
        pen = 1'b0;
        pwr = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        rst_n = 1'b0;
        n_fail = 0;
        tests_run = 0;
        void'($urandom(32'hBC3CC461));
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 3; i++) rchk(8'(4 * i), '1, 32'h0);
        apb(1'b0, 8'h40, 32'h0);
        chk({31'h0, er}, 32'h1);
        own = 10'($urandom_range(32'h6F, 32'h10));
        apb(1'b1, `ISF_OFF_OWN, {22'h0, own});
        i_peer.start();
        bus_byte({own[6:0], 1'b0}, 1'b0, 32'h2028, 32'h2008);
        d1 = 8'($urandom);
        bus_byte(d1, 1'b0, 32'h2062, 32'h2022);
        rchk(`ISF_OFF_RXDATA, 32'hFF, {24'h0, d1});
        rchk(`ISF_OFF_STATUS, 32'h2002, 32'h0);
        bus_byte(8'($urandom), 1'b0, 32'h42, 32'h02);
        bus_byte(8'($urandom), 1'b0, 32'h42, 32'h42);
        apb(1'b1, `ISF_OFF_STATUS, 32'hFFFF);
        rchk(`ISF_OFF_STATUS, 32'h40, 32'h40);
        apb(1'b1, `ISF_OFF_STATUS, 32'h0);
        rchk(`ISF_OFF_STATUS, 32'h40, 32'h0);
        i_peer.stop();
        rchk(`ISF_OFF_STATUS, 32'h2018, 32'h10);
        apb(1'b1, `ISF_OFF_CTRL, 32'h4);
        i_peer.start();
        bus_byte(8'h00, 1'b0, 32'h200, 32'h200);
        i_peer.stop();
        rchk(`ISF_OFF_STATUS, 32'h200, 32'h0);
        own = 10'($urandom);
        apb(1'b1, `ISF_OFF_OWN, {22'h0, own});
        apb(1'b1, `ISF_OFF_CTRL, 32'h2);
        i_peer.start();
        bus_byte({`ISF_TEN_HDR, own[9:8], 1'b0}, 1'b0, 32'h100, 32'h0);
        bus_byte(own[7:0], 1'b0, 32'h120, 32'h100);
        i_peer.stop();
        rchk(`ISF_OFF_STATUS, 32'h100, 32'h0);
        apb(1'b1, `ISF_OFF_CTRL, 32'h1);
        d1 = 8'($urandom);
        apb(1'b1, `ISF_OFF_TXDATA, {24'h0, d1});
        rchk(`ISF_OFF_STATUS, 32'h1, 32'h1);
        i_peer.start();
        bus_byte(8'hFF, 1'b0, 32'h4000, 32'h4000);
        chk({24'h0, seen}, {24'h0, d1});
        rchk(`ISF_OFF_STATUS, 32'hC000, 32'h8000);
        // the second write lands while the first byte is pending
        d1 = 8'($urandom);
        apb(1'b1, `ISF_OFF_TXDATA, {24'h0, d1});
        apb(1'b1, `ISF_OFF_TXDATA, {24'h0, ~d1});
        rchk(`ISF_OFF_STATUS, 32'h80, 32'h80);
        bus_byte(8'hFF, 1'b1, 32'hC080, 32'hC080);
        chk({24'h0, seen}, {24'h0, d1});
        rchk(`ISF_OFF_STATUS, 32'hC080, 32'h80);
        apb(1'b1, `ISF_OFF_STATUS, 32'h0);
        rchk(`ISF_OFF_STATUS, 32'h80, 32'h0);
        apb(1'b1, `ISF_OFF_TXDATA, 32'hA5);
        bus_byte(8'h00, 1'b1, 32'h400, 32'h400);
        apb(1'b1, `ISF_OFF_STATUS, 32'h0);
        rchk(`ISF_OFF_STATUS, 32'h400, 32'h0);
        i_peer.stop();
        close_out();
    end
endmodule
`default_nettype wire
